// File: typec_pins_defs.svh
`ifndef TYPEC_PINS_DEFS_SVH
`define TYPEC_PINS_DEFS_SVH

// ==========================================
// Target addresses
`define ADDR_HIGH_TARGET 7'h67
`define ADDR_LOW_TARGET 7'h47

// ==========================================
// Tri-level pin encodings
`define TRI_LOW 2'h0
`define TRI_OPEN 2'h1
`define TRI_HIGH 2'h2

// ==========================================
// Current level encodings
`define CUR_DEFAULT 2'h0
`define CUR_MEDIUM 2'h1
`define CUR_HIGH 2'h2

// ==========================================
// Synchroniser rest value: enables off, supply good, shared pins at pull-up
`define PIN_SYNC_RESET 5'h1F

`endif

// File: typec_pins_pkg.sv
package typec_pins_pkg;

    // Decoded level of a tri-level pin
    typedef enum logic [1:0]
    {
        TRI_LOW_E = 2'h0,
        TRI_OPEN_E = 2'h1,
        TRI_HIGH_E = 2'h2
    } tri_level_t;

    // Port role
    typedef enum logic [1:0]
    {
        UPSTREAM_ROLE = 2'h0,
        DUAL_ROLE = 2'h1,
        DOWNSTREAM_ROLE = 2'h2
    } port_role_t;

    // Current advertisement or detection level
    typedef enum logic [1:0]
    {
        CUR_DEFAULT_E = 2'h0,
        CUR_MEDIUM_E = 2'h1,
        CUR_HIGH_E = 2'h2
    } cur_level_t;

    // Status from the CC detection core
    typedef struct packed
    {
        logic attached;
        logic acting_source;
        logic orientation;
        logic audio_accessory;
        logic cable_power_overcurrent;
        cur_level_t detected_current;
    } cc_status_t;

    // Open-drain pin pair, output and enable
    typedef struct packed
    {
        logic out;
        logic oe;
    } od_drive_t;

endpackage

// File: typec_port_ctrl_status_pins.sv
`timescale 1ns/1ns
`include "typec_pins_defs.svh"

module typec_port_ctrl_status_pins
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Tri-level straps, already decoded, asynchronous
    input wire typec_pins_pkg::tri_level_t addr_select,
    input wire typec_pins_pkg::tri_level_t port_role_select,
    input wire typec_pins_pkg::tri_level_t current_level_select,
    // Enables and supply, asynchronous pins
    input wire logic switch_enable_low,
    input wire logic cc_logic_enable_low,
    input wire logic supply_5v_good,
    // From register logic, same clock
    input wire logic soft_reset,
    input wire logic reg_changed,
    input wire logic irq_clear,
    input wire typec_pins_pkg::cc_status_t cc_status,
    // Shared pin A: data or current flag
    input wire logic data_or_current_flag_a_in,
    output logic data_or_current_flag_a_out,
    output logic data_or_current_flag_a_oe,
    // Shared pin B: clock or current flag
    input wire logic clock_or_current_flag_b_in,
    output logic clock_or_current_flag_b_out,
    output logic clock_or_current_flag_b_oe,
    // I2C target side, to and from the serial engine
    input wire logic i2c_sda_drive_low,
    output logic i2c_enable,
    output logic [6:0] i2c_target_addr,
    output logic i2c_sda_in,
    output logic i2c_scl_in,
    // Open-drain status pins
    output logic orientation_out,
    output logic orientation_oe,
    output logic irq_or_audio_flag_out,
    output logic irq_or_audio_flag_oe,
    output logic cable_power_fault_low_out,
    output logic cable_power_fault_low_oe,
    output logic attach_as_source_low_out,
    output logic attach_as_source_low_oe,
    // Control to mux and CC core
    output logic mux_active,
    output logic cc_active,
    output typec_pins_pkg::port_role_t port_role,
    output typec_pins_pkg::cur_level_t advertised_current
);
    import typec_pins_pkg::*;

    // ==========================================
    // Input synchronisers
    // Three stages; a change counts when stages two and three agree
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] sync3_ff;
    logic [4:0] stable_ff;
    logic [4:0] raw_in;
    // Rest levels match the idle pins, so no false edge follows reset
    localparam logic [4:0] SYNC_RESET_BITS = `PIN_SYNC_RESET;

    assign raw_in = {switch_enable_low, cc_logic_enable_low, supply_5v_good,
                     data_or_current_flag_a_in, clock_or_current_flag_b_in};

    // Shift chain for all pin inputs except the tri-level straps
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sync1_ff <= SYNC_RESET_BITS;
            sync2_ff <= SYNC_RESET_BITS;
            sync3_ff <= SYNC_RESET_BITS;
        end
        else
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Accept a bit only once two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_filter
            always_ff @(posedge clock)
            begin
                if (srst)
                    stable_ff[gi] <= SYNC_RESET_BITS[gi];
                else if (sync2_ff[gi] == sync3_ff[gi])
                    stable_ff[gi] <= sync3_ff[gi];
            end
        end
    endgenerate

    logic mux_en_low_s;
    logic cc_en_low_s;
    logic supply_s;
    assign mux_en_low_s = stable_ff[4];
    assign cc_en_low_s = stable_ff[3];
    assign supply_s = stable_ff[2];

    // ==========================================
    // Straps
    // Straps are tied on the board; caught in clocked logic after reset
    logic gpio_mode_ff;
    logic [6:0] addr_ff;
    logic strap_taken_ff;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            gpio_mode_ff <= 1'b1;
            addr_ff <= 7'h00;
            strap_taken_ff <= 1'b0;
        end
        else if (!strap_taken_ff)
        begin
            strap_taken_ff <= 1'b1;
            gpio_mode_ff <= (addr_select == TRI_OPEN_E);
            unique case (addr_select)
                TRI_HIGH_E: addr_ff <= `ADDR_HIGH_TARGET;
                TRI_LOW_E: addr_ff <= `ADDR_LOW_TARGET;
                default: addr_ff <= 7'h00;
            endcase
        end
    end

    assign i2c_enable = strap_taken_ff && !gpio_mode_ff;
    assign i2c_target_addr = addr_ff;

    // ==========================================
    // Enables
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mux_active <= 1'b0;
            cc_active <= 1'b0;
        end
        else
        begin
            mux_active <= !mux_en_low_s;
            cc_active <= !cc_en_low_s && supply_s;
        end
    end

    // ==========================================
    // Port role sampling
    // Role is sampled on entry to the running state or on soft_reset, so a strap change mid-session waits for one of them
    logic cc_run;
    logic cc_run_d_ff;
    assign cc_run = !cc_en_low_s && supply_s;

    always_ff @(posedge clock)
    begin
        if (srst)
            cc_run_d_ff <= 1'b0;
        else
            cc_run_d_ff <= cc_run;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            port_role <= DUAL_ROLE;
        else if ((cc_run && !cc_run_d_ff) || soft_reset)
        begin
            unique case (port_role_select)
                TRI_HIGH_E: port_role <= DOWNSTREAM_ROLE;
                TRI_LOW_E: port_role <= UPSTREAM_ROLE;
                default: port_role <= DUAL_ROLE;
            endcase
        end
    end

    // Advertised current from strap; only meaningful when sourcing
    always_ff @(posedge clock)
    begin
        if (srst)
            advertised_current <= CUR_DEFAULT_E;
        else if (port_role == UPSTREAM_ROLE)
            advertised_current <= CUR_DEFAULT_E;
        else
        begin
            unique case (current_level_select)
                TRI_HIGH_E: advertised_current <= CUR_HIGH_E;
                TRI_OPEN_E: advertised_current <= CUR_MEDIUM_E;
                default: advertised_current <= CUR_DEFAULT_E;
            endcase
        end
    end

    // ==========================================
    // Interrupt latch
    // Set wins over clear so a change in the clear cycle is kept
    logic irq_pending_ff;

    always_ff @(posedge clock)
    begin
        if (srst)
            irq_pending_ff <= 1'b0;
        else if (reg_changed)
            irq_pending_ff <= 1'b1;
        else if (irq_clear)
            irq_pending_ff <= 1'b0;
    end

    // ==========================================
    // Open-drain pull-low requests
    logic pull_a;
    logic pull_b;
    logic pull_irq;
    logic sink_gpio;
    assign sink_gpio = gpio_mode_ff && (port_role != DOWNSTREAM_ROLE) && !cc_status.acting_source;
    assign pull_a = gpio_mode_ff ? (sink_gpio && cc_status.attached &&
                    cc_status.detected_current != CUR_DEFAULT_E)
                    : i2c_sda_drive_low;
    assign pull_b = sink_gpio && cc_status.attached &&
                    cc_status.detected_current == CUR_HIGH_E;
    assign pull_irq = gpio_mode_ff ? cc_status.audio_accessory
                      : irq_pending_ff;

    // Output drives; a pin is pulled low or released, never driven high
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            data_or_current_flag_a_oe <= 1'b0;
            clock_or_current_flag_b_oe <= 1'b0;
            irq_or_audio_flag_oe <= 1'b0;
            orientation_oe <= 1'b0;
            cable_power_fault_low_oe <= 1'b0;
            attach_as_source_low_oe <= 1'b0;
        end
        else
        begin
            data_or_current_flag_a_oe <= pull_a;
            clock_or_current_flag_b_oe <= pull_b;
            irq_or_audio_flag_oe <= pull_irq;
            orientation_oe <= cc_active && cc_status.orientation;
            cable_power_fault_low_oe <= cc_status.cable_power_overcurrent;
            attach_as_source_low_oe <= cc_active && cc_status.attached &&
                ((port_role == DOWNSTREAM_ROLE) ||
                 (port_role == DUAL_ROLE && cc_status.acting_source));
        end
    end

    // Data of every open-drain pin is a constant low
    assign data_or_current_flag_a_out = 1'b0;
    assign clock_or_current_flag_b_out = 1'b0;
    assign irq_or_audio_flag_out = 1'b0;
    assign orientation_out = 1'b0;
    assign cable_power_fault_low_out = 1'b0;
    assign attach_as_source_low_out = 1'b0;

    // Filtered pin levels to the serial engine; idle high in GPIO mode
    assign i2c_sda_in = gpio_mode_ff ? 1'b1 : stable_ff[1];
    assign i2c_scl_in = gpio_mode_ff ? 1'b1 : stable_ff[0];

endmodule // typec_port_ctrl_status_pins

// File: typec_pins_props.sv
`timescale 1ns/1ns
// ==========
// Port checker
module typec_pins_props
    import typec_pins_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Causes
    input wire logic switch_enable_low,
    input wire logic cc_logic_enable_low,
    input wire logic supply_5v_good,
    input wire logic reg_changed,
    input wire logic irq_clear,
    input wire typec_pins_pkg::cc_status_t cc_status,
    // Effects
    input wire logic i2c_enable,
    input wire logic orientation_oe,
    input wire logic irq_or_audio_flag_oe,
    input wire logic cable_power_fault_low_oe,
    input wire logic mux_active,
    input wire logic cc_active
);
    // Pins pass a synchroniser, so level rules allow eight cycles
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    irq_set_a: assert property (
        reg_changed && i2c_enable |-> ##2 irq_or_audio_flag_oe) else $error("irq not set");
    irq_clear_a: assert property (
        irq_clear && !reg_changed && i2c_enable |-> ##2 !irq_or_audio_flag_oe)
        else $error("irq not cleared");
    fault_follow_a: assert property (
        $past(!srst) |-> cable_power_fault_low_oe == $past(cc_status.cable_power_overcurrent))
        else $error("fault pin wrong");
    orient_follow_a: assert property (
        cc_active && $past(cc_active) && $past(cc_active, 2)
        |-> orientation_oe == $past(cc_status.orientation)) else $error("orientation wrong");
    mux_on_a: assert property (!switch_enable_low [*8] |-> mux_active)
        else $error("mux not on");
    mux_off_a: assert property (switch_enable_low [*8] |-> !mux_active)
        else $error("mux not off");
    cc_on_a: assert property (
        (!cc_logic_enable_low && supply_5v_good) [*8] |-> cc_active) else $error("cc not on");
    cc_off_a: assert property (cc_logic_enable_low [*8] |-> !cc_active)
        else $error("cc not off");
    cover property (reg_changed && i2c_enable);
    cover property (!i2c_enable && irq_or_audio_flag_oe);
    cover property ($rose(cable_power_fault_low_oe));
    cover property (reg_changed && irq_clear && i2c_enable);
endmodule // typec_pins_props

bind typec_port_ctrl_status_pins typec_pins_props i_props (.*);

// File: board_pins_model.sv
`timescale 1ns/1ns
// ==========
// Board pull-ups and host clock driver
module board_pins_model
(
    // Drive enables
    input wire logic a_oe,
    input wire logic b_oe,
    input wire logic host_scl_low,
    // Line levels
    output logic pin_a,
    output logic pin_b
);
    // Released lines rise to the pull-up, never hold the last value
    assign pin_a = !a_oe;
    assign pin_b = !(b_oe || host_scl_low);
endmodule // board_pins_model

// File: tb_typec_port_ctrl_status_pins.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
// ==========
// Testbench
module tb_typec_port_ctrl_status_pins;
    import typec_pins_pkg::*;
    logic clock = 0, srst = 1, switch_enable_low = 0, cc_logic_enable_low = 0;
    logic supply_5v_good = 1, soft_reset = 0, reg_changed = 0, irq_clear = 0;
    logic i2c_sda_drive_low = 0, host_scl_low = 0, pin_a, pin_b, i2c_enable, i2c_sda_in;
    logic i2c_scl_in, orientation_oe, irq_or_audio_flag_oe, cable_power_fault_low_oe;
    logic data_or_current_flag_a_oe, clock_or_current_flag_b_oe, attach_as_source_low_oe;
    logic mux_active, cc_active;
    logic [5:0] od_out;
    logic [2:0] gpio_oe;
    logic [6:0] i2c_target_addr;
    tri_level_t addr_select = TRI_HIGH_E, port_role_select = TRI_HIGH_E;
    tri_level_t current_level_select = TRI_HIGH_E;
    cc_status_t cc_status = '0;
    port_role_t port_role;
    cur_level_t advertised_current;
    int n_mismatch = 0, n_tests = 0;
    // Strap cases: address high, low, open; role strap high, open, low
    tri_level_t sel_t[3] = '{TRI_HIGH_E, TRI_OPEN_E, TRI_LOW_E};
    tri_level_t addr_t[3] = '{TRI_HIGH_E, TRI_LOW_E, TRI_OPEN_E};
    logic [6:0] exp_addr[3] = '{7'h67, 7'h47, 7'h00};
    port_role_t exp_role[3] = '{DOWNSTREAM_ROLE, DUAL_ROLE, UPSTREAM_ROLE};
    cur_level_t exp_cur[3] = '{CUR_HIGH_E, CUR_MEDIUM_E, CUR_DEFAULT_E};

    typec_port_ctrl_status_pins i_dut (.*, .data_or_current_flag_a_in(pin_a),
        .clock_or_current_flag_b_in(pin_b), .data_or_current_flag_a_out(od_out[5]),
        .clock_or_current_flag_b_out(od_out[4]), .orientation_out(od_out[3]),
        .irq_or_audio_flag_out(od_out[2]), .cable_power_fault_low_out(od_out[1]),
        .attach_as_source_low_out(od_out[0]));
    board_pins_model i_board (.a_oe(data_or_current_flag_a_oe),
        .b_oe(clock_or_current_flag_b_oe), .host_scl_low(host_scl_low), .pin_a(pin_a),
        .pin_b(pin_b));

    // Pull-low requests of the three shared status pins
    assign gpio_oe = {data_or_current_flag_a_oe, clock_or_current_flag_b_oe, irq_or_audio_flag_oe};

    // 100 ns clock
    always #50 clock = ~clock;

    // Wait to the n-th falling edge, when registered outputs stand still
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        wt(3000);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence, one pass per address strap; inputs change at rising edges
    initial
    begin
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock);
            srst <= 1'h1;
            addr_select <= addr_t[i];
            port_role_select <= sel_t[i];
            current_level_select <= (i == 2) ? TRI_HIGH_E : sel_t[i];
            repeat (5) @(posedge clock);
            srst <= 1'h0;
            // Right after the strap is taken the serial lines must read idle high
            wt(2);
            `CHK({i2c_sda_in, i2c_scl_in}, 2'h3)
            wt(9);
            `CHK(i2c_target_addr, exp_addr[i])
            `CHK(i2c_enable, i < 2)
            `CHK(port_role, exp_role[i])
            `CHK(advertised_current, exp_cur[i])
            `CHK(od_out, 6'h00)
            @(posedge clock);
            switch_enable_low <= 1'h1;
            cc_logic_enable_low <= 1'h1;
            wt(8);
            `CHK({mux_active, cc_active}, 2'h0)
            // Enables low but no 5 V: the mux runs, the CC logic does not
            @(posedge clock);
            switch_enable_low <= 1'h0;
            cc_logic_enable_low <= 1'h0;
            supply_5v_good <= 1'h0;
            wt(8);
            `CHK({mux_active, cc_active}, 2'h2)
            @(posedge clock);
            supply_5v_good <= 1'h1;
            cc_status <= {1'h1, i != 2, 3'h5, CUR_DEFAULT_E};
            wt(8);
            `CHK({mux_active, cc_active, orientation_oe}, 3'h7)
            `CHK({cable_power_fault_low_oe, attach_as_source_low_oe}, {1'h1, i != 2})
            @(posedge clock);
            cc_status <= '0;
            wt(3);
            `CHK({orientation_oe, cable_power_fault_low_oe, attach_as_source_low_oe}, 3'h0)
            if (i < 2)
            begin
                // Change and clear in one cycle: the change must win
                @(posedge clock);
                reg_changed <= 1'h1;
                irq_clear <= 1'h1;
                @(posedge clock);
                reg_changed <= 1'h0;
                irq_clear <= 1'h0;
                wt(3);
                `CHK(irq_or_audio_flag_oe, 1'h1)
                @(posedge clock);
                irq_clear <= 1'h1;
                i2c_sda_drive_low <= 1'h1;
                host_scl_low <= 1'h1;
                @(posedge clock);
                irq_clear <= 1'h0;
                wt(8);
                `CHK({irq_or_audio_flag_oe, data_or_current_flag_a_oe}, 2'h1)
                `CHK({i2c_sda_in, i2c_scl_in}, 2'h0)
                @(posedge clock);
                i2c_sda_drive_low <= 1'h0;
                host_scl_low <= 1'h0;
                wt(8);
                `CHK({i2c_sda_in, i2c_scl_in}, 2'h3)
            end
            else
            begin
                @(posedge clock);
                cc_status <= 7'h08;
                port_role_select <= TRI_OPEN_E;
                wt(3);
                `CHK(irq_or_audio_flag_oe, 1'h1)
                // Sink current flags for each detected level, no accessory
                for (int c = 0; c < 3; c++)
                begin
                    @(posedge clock);
                    cc_status <= {5'h10, c[1:0]};
                    wt(3);
                    `CHK(gpio_oe, {c != 0, c == 2, 1'b0})
                end
                // Role strap moved mid-session: ignored until a soft reset
                `CHK(port_role, UPSTREAM_ROLE)
                @(posedge clock);
                soft_reset <= 1'h1;
                @(posedge clock);
                soft_reset <= 1'h0;
                wt(3);
                `CHK(port_role, DUAL_ROLE)
                `CHK(advertised_current, CUR_HIGH_E)
            end
        end
        print_verdict();
    end
endmodule // tb_typec_port_ctrl_status_pins
